//--- hw/cvs_pkg.sv
// conveyor run sequencer: register map, field layout, reset values, timing
// assumes a 10 MHz pclk and 32-bit apb data with byte addresses
package cvs_pkg;

  // timing base
  localparam int unsigned CLK_PERIOD_NS = 100;
  localparam int unsigned MS_TIME_NS    = 1000000;
  localparam int unsigned MS_CYCLES     = (MS_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // counter and field widths
  localparam int TW     = 16;
  localparam int AW     = 8;
  localparam int NADR_W = 8;
  localparam int CTRL_W = 5;

  // register byte addresses
  localparam logic [AW-1:0] OFS_CTRL   = 8'h00;
  localparam logic [AW-1:0] OFS_LEAD   = 8'h04;
  localparam logic [AW-1:0] OFS_OVR    = 8'h08;
  localparam logic [AW-1:0] OFS_PERIOD = 8'h0c;
  localparam logic [AW-1:0] OFS_TMO    = 8'h10;
  localparam logic [AW-1:0] OFS_PHASE  = 8'h14;
  localparam logic [AW-1:0] OFS_ADDR   = 8'h18;
  localparam logic [AW-1:0] OFS_STAT   = 8'h1c;

  // control register bits
  localparam int CB_SLAVE    = 0;
  localparam int CB_MASTER   = 1;
  localparam int CB_KEYS_OFF = 2;
  localparam int CB_AIR_ASG  = 3;
  localparam int CB_FREQ     = 4;

  // status register bits
  localparam int SB_STATE  = 0;
  localparam int SB_MAGNET = 2;
  localparam int SB_AIR    = 3;
  localparam int SB_SYNC   = 4;
  localparam int SB_SLAVE  = 5;
  localparam int SB_KEYPAS = 6;
  localparam int SB_LATCH  = 7;
  localparam int STAT_W    = 8;

  // reset values
  localparam logic [CTRL_W-1:0] CTRL_RST   = 5'h00;
  localparam logic [TW-1:0]     LEAD_RST   = 16'h001e;
  localparam logic [TW-1:0]     OVR_RST    = 16'h001e;
  localparam logic [TW-1:0]     PERIOD_RST = 16'h07d0;
  localparam logic [TW-1:0]     TMO_RST    = 16'h1388;
  localparam logic [TW-1:0]     PHASE_RST  = 16'h0000;
  localparam logic [NADR_W-1:0] ADDR_RST   = 8'h01;

  typedef enum logic [1:0] {
    CVS_STOP = 2'b00,
    CVS_LEAD = 2'b01,
    CVS_RUN  = 2'b10,
    CVS_OVR  = 2'b11
  } cvs_state_t;

endpackage

//--- hw/cvs_seq.sv
// conveyor run sequencer: apb registers, run/stop state, sorting-air timing,
// master sync pulse generation and slave sync following
// assumes all pins synchronous to pclk; keys give one-cycle pulses

// Overview of operation
// (RQ1) on release air first, conveyor after lead
// (RQ2) air stays on for overrun after stop
// (RQ3) lead and overrun times set separately
// (RQ4) air only when air function assigned
// (RQ5) master sends sync pulses, slaves follow
// (RQ6) slave runs only while sync pulses arrive
// (RQ7) slave stops shortly after pulses cease
// (RQ8) at most ten slaves per master bus
// (RQ9) slave: amplitude control only, master frequency
// (RQ10) master may run amplitude and frequency control
// (RQ11) sync pins reserved during master/slave mode; gp_in3 still follows the sync input in master mode
// (RQ12) control bit enables slave operation
// (RQ13) slave applies configurable phase offset
// (RQ14) bus node address is configurable
// (RQ15) setting disables front run and off keys
// (RQ16) magnet off after power-up by default
// (RQ17) power-up-on option starts magnet immediately
// (RQ18) power-up-on forbids passive keys
// (RQ19) release needs run key or external enable
// (RQ20) re-release during overrun keeps air on
// (RQ21) sync loss by counter reloaded per pulse
module cvs_seq
  import cvs_pkg::*;
#(
  parameter int unsigned MS_DIV = MS_CYCLES
)(
  input  wire logic              pclk,
  input  wire logic              presetn,
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [AW-1:0]     paddr,
  input  wire logic [31:0]       pwdata,
  output logic      [31:0]       prdata,
  output logic                   pready,
  output logic                   pslverr,
  input  wire logic              run_key,
  input  wire logic              off_key,
  input  wire logic              ext_enable,
  input  wire logic              pon_on,
  input  wire logic              sync_pulse_input,
  input  wire logic              gp_sync_pulse_output_req,
  output logic                   sync_pulse_output,
  output logic                   gp_in3,
  output logic                   slave_freq_pulse,
  output logic                   air_out,
  output logic                   magnet_on,
  output logic                   amp_ctrl_en,
  output logic                   freq_ctrl_en,
  output logic                   pin3_reserved,
  output logic      [NADR_W-1:0] bus_node_address
);

  // elaboration check: the tick divider needs at least two cycles per tick
  if (MS_DIV < 2 || MS_DIV > 32'hffff_fff) $error("cvs_seq: MS_DIV out of range");

  // apb decode
  logic apb_wr;
  logic apb_rd_setup;
  logic hit;
  assign apb_wr       = psel && penable && pwrite;
  assign apb_rd_setup = psel && !penable && !pwrite;
  assign hit = (paddr == OFS_CTRL) || (paddr == OFS_LEAD) || (paddr == OFS_OVR) ||
               (paddr == OFS_PERIOD) || (paddr == OFS_TMO) || (paddr == OFS_PHASE) ||
               (paddr == OFS_ADDR) || (paddr == OFS_STAT);
  assign pready  = 1'b1;
  assign pslverr = psel && penable && !hit;

  // configuration registers
  logic [CTRL_W-1:0] ctrl_q, ctrl_d;
  logic [TW-1:0]     lead_q, lead_d, ovr_q, ovr_d;
  logic [TW-1:0]     period_q, period_d, tmo_q, tmo_d, phase_q, phase_d;
  logic [NADR_W-1:0] nadr_q, nadr_d;
  logic [31:0]       rdata_q, rdata_d;
  logic [STAT_W-1:0] status;

  // register writes in the access cycle, read data captured in the setup cycle
  always_comb
  begin
    ctrl_d   = ctrl_q;
    lead_d   = lead_q;
    ovr_d    = ovr_q;
    period_d = period_q;
    tmo_d    = tmo_q;
    phase_d  = phase_q;
    nadr_d   = nadr_q;
    rdata_d  = rdata_q;
    if (apb_wr)
    begin
      unique case (paddr)
        OFS_CTRL:   ctrl_d   = pwdata[CTRL_W-1:0]; // RQ12
        OFS_LEAD:   lead_d   = pwdata[TW-1:0];     // RQ3
        OFS_OVR:    ovr_d    = pwdata[TW-1:0];     // RQ3
        OFS_PERIOD: period_d = pwdata[TW-1:0];
        OFS_TMO:    tmo_d    = pwdata[TW-1:0];
        OFS_PHASE:  phase_d  = pwdata[TW-1:0];     // RQ13
        OFS_ADDR:   nadr_d   = pwdata[NADR_W-1:0]; // RQ14
        default:    ;
      endcase
    end
    if (apb_rd_setup)
    begin
      unique case (paddr)
        OFS_CTRL:   rdata_d = {{(32-CTRL_W){1'b0}}, ctrl_q};
        OFS_LEAD:   rdata_d = {{(32-TW){1'b0}}, lead_q};
        OFS_OVR:    rdata_d = {{(32-TW){1'b0}}, ovr_q};
        OFS_PERIOD: rdata_d = {{(32-TW){1'b0}}, period_q};
        OFS_TMO:    rdata_d = {{(32-TW){1'b0}}, tmo_q};
        OFS_PHASE:  rdata_d = {{(32-TW){1'b0}}, phase_q};
        OFS_ADDR:   rdata_d = {{(32-NADR_W){1'b0}}, nadr_q};
        OFS_STAT:   rdata_d = {{(32-STAT_W){1'b0}}, status};
        default:    rdata_d = '0;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      ctrl_q   <= CTRL_RST;
      lead_q   <= LEAD_RST;
      ovr_q    <= OVR_RST;
      period_q <= PERIOD_RST;
      tmo_q    <= TMO_RST;
      phase_q  <= PHASE_RST;
      nadr_q   <= ADDR_RST;
      rdata_q  <= '0;
    end
    else
    begin
      ctrl_q   <= ctrl_d;
      lead_q   <= lead_d;
      ovr_q    <= ovr_d;
      period_q <= period_d;
      tmo_q    <= tmo_d;
      phase_q  <= phase_d;
      nadr_q   <= nadr_d;
      rdata_q  <= rdata_d;
    end
  end

  assign prdata           = rdata_q;
  assign bus_node_address = nadr_q; // RQ14
  // mode decode; slave has priority over master
  logic slave_mode, master_mode, air_asg, keys_passive;
  assign slave_mode   = ctrl_q[CB_SLAVE];                   // RQ12
  assign master_mode  = ctrl_q[CB_MASTER] && !slave_mode;
  assign air_asg      = ctrl_q[CB_AIR_ASG];
  assign keys_passive = ctrl_q[CB_KEYS_OFF] && !pon_on;     // RQ18

  // millisecond tick divider for air timing
  logic [31:0] div_q, div_d;
  logic        ms_tick;
  assign ms_tick = (div_q == MS_DIV - 1);
  always_comb
    div_d = ms_tick ? '0 : div_q + 32'd1;
  // timers: air lead/overrun, sync loss, slave phase offset
  cvs_tmr_if #(.W(TW)) air_t ();
  cvs_tmr_if #(.W(TW)) loss_t ();
  cvs_tmr_if #(.W(TW)) ph_t ();
  cvs_timer #(.W(TW)) u_air  (.pclk(pclk), .presetn(presetn), .t(air_t));
  cvs_timer #(.W(TW)) u_loss (.pclk(pclk), .presetn(presetn), .t(loss_t));
  cvs_timer #(.W(TW)) u_ph   (.pclk(pclk), .presetn(presetn), .t(ph_t));
  // sync pulse edge detect and loss counter reloaded on every pulse
  logic sync_in_q, sync_rise, sync_present;
  assign sync_rise    = slave_mode && sync_pulse_input && !sync_in_q;
  assign sync_present = loss_t.busy;                        // RQ21
  assign loss_t.load  = sync_rise;                          // RQ21
  assign loss_t.clear = !slave_mode;
  assign loss_t.value = tmo_q;
  assign loss_t.tick  = 1'b1;

  // phase-shifted slave timing pulse
  assign ph_t.load  = sync_rise;                            // RQ13
  assign ph_t.clear = !slave_mode;
  assign ph_t.value = phase_q;
  assign ph_t.tick  = 1'b1;
  // run latch from keys, power-up option caught after reset release
  logic latch_q, latch_d, init_q, release_req;
  always_comb
  begin
    latch_d = latch_q;
    if (!init_q)
      latch_d = pon_on;                                     // RQ16 RQ17
    else if (!keys_passive && off_key)
      latch_d = 1'b0;                                       // RQ15
    else if (!keys_passive && run_key)
      latch_d = 1'b1;                                       // RQ15
  end
  assign release_req = (keys_passive ? ext_enable : (latch_q || ext_enable)) // RQ19
                       && (!slave_mode || sync_present);    // RQ6 RQ7

  // run state machine
  cvs_state_t state_q, state_d;
  logic       air_q, air_d, mag_q, mag_d;
  always_comb
  begin
    state_d       = state_q;
    air_t.load    = 1'b0;
    air_t.clear   = 1'b0;
    air_t.value   = lead_q;
    unique case (state_q)
      CVS_STOP:
        if (release_req)
        begin
          if (air_asg)
          begin
            state_d    = CVS_LEAD;                          // RQ1
            air_t.load = 1'b1;
          end
          else
            state_d = CVS_RUN;                              // RQ4
        end
      CVS_LEAD:
        if (!release_req)
        begin
          state_d     = CVS_STOP;
          air_t.clear = 1'b1;
        end
        else if (air_t.done)
          state_d = CVS_RUN;                                // RQ1
      CVS_RUN:
        if (!release_req)
        begin
          if (air_asg)
          begin
            state_d     = CVS_OVR;                          // RQ2
            air_t.value = ovr_q;
            air_t.load  = 1'b1;
          end
          else
            state_d = CVS_STOP;
        end
      CVS_OVR:
        if (release_req)
        begin
          state_d     = CVS_RUN;                            // RQ20
          air_t.clear = 1'b1;
        end
        else if (air_t.done || !air_asg)
          state_d = CVS_STOP;                               // RQ2
    endcase
    air_d = air_asg && (state_d != CVS_STOP);               // RQ4
    mag_d = (state_d == CVS_RUN);
  end
  assign air_t.tick = ms_tick;

  // master sync pulse generator while running
  logic [TW-1:0] per_q, per_d;
  logic          mpulse_q, mpulse_d;
  always_comb
  begin
    per_d    = per_q;
    mpulse_d = 1'b0;
    if (!master_mode || !mag_q)
      per_d = '0;
    else if (per_q >= period_q)
    begin
      per_d    = '0;
      mpulse_d = 1'b1;                                      // RQ5
    end
    else
      per_d = per_q + TW'(1);
  end

  // pin 3 usage: sync output reserved while master or slave is set, gp_in3 held low only while slave is set
  logic sync_out_d, gp_in3_d, sfreq_d;
  always_comb
  begin
    sync_out_d = master_mode ? mpulse_d : (!slave_mode && gp_sync_pulse_output_req); // RQ11
    gp_in3_d   = !slave_mode && sync_pulse_input;           // RQ11
    sfreq_d    = slave_mode ? ph_t.done : mpulse_d;         // RQ5 RQ9
  end
  // state, outputs and helper registers
  logic sync_out_q, gp_in3_q, sfreq_q;
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      state_q    <= CVS_STOP;
      air_q      <= 1'b0;
      mag_q      <= 1'b0;
      latch_q    <= 1'b0;
      init_q     <= 1'b0;
      div_q      <= '0;
      sync_in_q  <= 1'b0;
      per_q      <= '0;
      mpulse_q   <= 1'b0;
      sync_out_q <= 1'b0;
      gp_in3_q   <= 1'b0;
      sfreq_q    <= 1'b0;
    end
    else
    begin
      state_q    <= state_d;
      air_q      <= air_d;
      mag_q      <= mag_d;
      latch_q    <= latch_d;
      init_q     <= 1'b1;
      div_q      <= div_d;
      sync_in_q  <= sync_pulse_input;
      per_q      <= per_d;
      mpulse_q   <= mpulse_d;
      sync_out_q <= sync_out_d;
      gp_in3_q   <= gp_in3_d;
      sfreq_q    <= sfreq_d;
    end
  end

  assign air_out           = air_q;
  assign magnet_on         = mag_q;
  assign sync_pulse_output = sync_out_q;
  assign gp_in3            = gp_in3_q;
  assign slave_freq_pulse  = sfreq_q;
  assign pin3_reserved     = slave_mode || ctrl_q[CB_MASTER];              // RQ11
  assign amp_ctrl_en       = mag_q;                                        // RQ9 RQ10
  assign freq_ctrl_en      = mag_q && !slave_mode && ctrl_q[CB_FREQ];      // RQ9 RQ10

  // status word
  always_comb
  begin
    status                   = '0;
    status[SB_STATE +: 2]    = state_q;
    status[SB_MAGNET]        = mag_q;
    status[SB_AIR]           = air_q;
    status[SB_SYNC]          = sync_present;
    status[SB_SLAVE]         = slave_mode;
    status[SB_KEYPAS]        = keys_passive;
    status[SB_LATCH]         = latch_q;
  end

endmodule

//--- hw/cvs_timer.sv
// countdown timer: load a count, step down on tick, one-cycle done at zero
// assumes pclk domain, asynchronous active-low reset
module cvs_timer
  import cvs_pkg::*;
#(
  parameter int W = 16
)(
  input wire logic pclk,
  input wire logic presetn,
  cvs_tmr_if.tmr   t
);

  logic [W-1:0] cnt_q;
  logic [W-1:0] cnt_d;
  logic         busy_q;
  logic         busy_d;
  logic         done_q;
  logic         done_d;

  // next count: load wins, clear cancels, expiry at zero
  always_comb
  begin
    cnt_d  = cnt_q;
    busy_d = busy_q;
    done_d = 1'b0;
    if (t.load)
    begin
      cnt_d  = t.value;
      busy_d = 1'b1;
    end
    else if (t.clear)
      busy_d = 1'b0;
    else if (busy_q && (cnt_q == '0))
    begin
      busy_d = 1'b0;
      done_d = 1'b1;
    end
    else if (busy_q && t.tick)
      cnt_d = cnt_q - W'(1);
  end

  // registers
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      cnt_q  <= '0;
      busy_q <= 1'b0;
      done_q <= 1'b0;
    end
    else
    begin
      cnt_q  <= cnt_d;
      busy_q <= busy_d;
      done_q <= done_d;
    end
  end

  assign t.done = done_q;
  assign t.busy = busy_q;

endmodule

//--- hw/cvs_tmr_if.sv
// control/status link between the sequencer and one countdown timer
// assumes both ends share pclk
interface cvs_tmr_if #(parameter int W = 16);
  logic         load;
  logic         clear;
  logic [W-1:0] value;
  logic         tick;
  logic         done;
  logic         busy;

  modport ctl (output load, output clear, output value, output tick,
               input done, input busy);
  modport tmr (input load, input clear, input value, input tick,
               output done, output busy);
endinterface

//--- test/cvs_master_model.sv
// partner: master unit sending one-cycle sync pulses to one slave
// assumes pclk domain; the pulse line idles low between pulses
module cvs_master_model
(
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        en,
  input  wire logic [15:0] period,
  output logic             pulse
);
  timeunit 1ns;
  timeprecision 1ns;
  int cnt;
  // one pulse every period cycles while enabled, one master per bus
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      cnt <= 0;
      pulse <= 1'b0;
    end
    else
    begin
      cnt <= (!en || cnt >= period - 1) ? 0 : cnt + 1;
      pulse <= en && cnt == 0;
    end
  end
endmodule

//--- test/cvs_seq_properties.sv
// checker: port-level relations of the run sequencer
// assumes bind onto cvs_seq; one pclk domain, presetn async active low
module cvs_seq_properties
  import cvs_pkg::*;
(
  input wire logic              pclk,
  input wire logic              presetn,
  input wire logic              psel,
  input wire logic              penable,
  input wire logic              pwrite,
  input wire logic              pready,
  input wire logic              pslverr,
  input wire logic              sync_pulse_input,
  input wire logic              gp_sync_pulse_output_req,
  input wire logic              sync_pulse_output,
  input wire logic              gp_in3,
  input wire logic              air_out,
  input wire logic              magnet_on,
  input wire logic              amp_ctrl_en,
  input wire logic              freq_ctrl_en,
  input wire logic              pin3_reserved,
  input wire logic [NADR_W-1:0] bus_node_address
);
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  // bus answers at once, errors only inside an access phase
  property p_rdy;
    pready;
  endproperty
  a_rdy: assert property (p_rdy) else $error("pready low");
  property p_err;
    pslverr |-> psel && penable;
  endproperty
  a_err: assert property (p_err) else $error("pslverr outside access");
  // air comes before and leaves after the magnet
  property p_air_rise;
    $rose(air_out) |-> !magnet_on;
  endproperty
  a_air_rise: assert property (p_air_rise) else $error("air late");
  property p_air_fall;
    $fell(air_out) |-> !magnet_on;
  endproperty
  a_air_fall: assert property (p_air_fall) else $error("air early off");
  // control enables follow the magnet
  property p_amp;
    amp_ctrl_en == magnet_on;
  endproperty
  a_amp: assert property (p_amp) else $error("amp enable wrong");
  property p_freq;
    freq_ctrl_en |-> magnet_on;
  endproperty
  a_freq: assert property (p_freq) else $error("freq without run");
  // pin 3 carries general functions when not reserved; gp_in3 also follows the sync input in master mode
  property p_gp_in;
    !pin3_reserved |=> gp_in3 == $past(sync_pulse_input);
  endproperty
  a_gp_in: assert property (p_gp_in) else $error("gp input wrong");
  property p_gp_out;
    !pin3_reserved |=> sync_pulse_output == $past(gp_sync_pulse_output_req);
  endproperty
  a_gp_out: assert property (p_gp_out) else $error("gp output wrong");
  // node address moves only on a bus write
  property p_addr;
    !(psel && penable && pwrite) |=> $stable(bus_node_address);
  endproperty
  a_addr: assert property (p_addr) else $error("address moved");
endmodule
bind cvs_seq cvs_seq_properties u_chk (.pclk(pclk), .presetn(presetn), .psel(psel),
  .penable(penable), .pwrite(pwrite), .pready(pready), .pslverr(pslverr),
  .sync_pulse_input(sync_pulse_input), .gp_sync_pulse_output_req(gp_sync_pulse_output_req),
  .sync_pulse_output(sync_pulse_output), .gp_in3(gp_in3), .air_out(air_out),
  .magnet_on(magnet_on), .amp_ctrl_en(amp_ctrl_en), .freq_ctrl_en(freq_ctrl_en),
  .pin3_reserved(pin3_reserved), .bus_node_address(bus_node_address));

//--- test/test_cvs_seq.sv
// testbench: registers, run and air timing, slave and master sync
// assumes package, design, checker and master model compiled before
module test_cvs_seq;
  timeunit 1ns;
  timeprecision 1ns;
  typedef struct packed {logic [7:0] a; logic [31:0] d; logic e;} cvs_row_t;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, er;
  logic [7:0]  paddr, bus_node_address;
  logic [31:0] pwdata, prdata, rd;
  logic        run_key, off_key, ext_enable, pon_on, gp_sync_pulse_output_req, men;
  logic        sync_pulse_input, sync_pulse_output, gp_in3, slave_freq_pulse;
  logic        air_out, magnet_on, amp_ctrl_en, freq_ctrl_en, pin3_reserved;
  logic [15:0] mper;
  int          err_total, checked, n;
  cvs_row_t    rows [9];
  cvs_seq #(.MS_DIV(10)) uut (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .run_key(run_key),
    .off_key(off_key), .ext_enable(ext_enable), .pon_on(pon_on),
    .sync_pulse_input(sync_pulse_input), .gp_sync_pulse_output_req(gp_sync_pulse_output_req),
    .sync_pulse_output(sync_pulse_output), .gp_in3(gp_in3),
    .slave_freq_pulse(slave_freq_pulse), .air_out(air_out), .magnet_on(magnet_on),
    .amp_ctrl_en(amp_ctrl_en), .freq_ctrl_en(freq_ctrl_en),
    .pin3_reserved(pin3_reserved), .bus_node_address(bus_node_address));
  cvs_master_model u_mst (.pclk(pclk), .presetn(presetn), .en(men), .period(mper),
    .pulse(sync_pulse_input));
  // 100 ns clock
  always #50 pclk = ~pclk;
  // verdict and end of run
  task automatic conclude();
    $display("checks %0d mismatches %0d", checked, err_total);
    if (err_total == 0 && checked > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  // compare seen against expected
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    checked++;
    if (s !== e)
    begin
      err_total++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask
  task automatic tmo();
    chk(32'h0, 32'h1);
    conclude();
  endtask
  task automatic rng(input int lo, input int hi);
    chk(32'(n >= lo && n <= hi), 32'h1);
  endtask
  task automatic cyc(input int k);
    repeat (k) @(posedge pclk);
  endtask
  // wait until air and magnet show the given levels, n counts cycles
  task automatic wt(input logic a, input logic m, input int lim);
    n = 0;
    while ((air_out !== a || magnet_on !== m) && n < lim)
    begin
      @(posedge pclk);
      n++;
    end
    if (air_out !== a || magnet_on !== m) tmo();
  endtask
  function automatic logic sig(input int s);
    return s == 0 ? sync_pulse_input : s == 1 ? slave_freq_pulse : sync_pulse_output;
  endfunction
  // wait for a pulse line to go high
  task automatic wh(input int s);
    n = 0;
    while (sig(s) !== 1'b1 && n < 200)
    begin
      @(posedge pclk);
      n++;
    end
    if (sig(s) !== 1'b1) tmo();
  endtask
  // one apb transfer: setup, access held until pready
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int k;
    @(posedge pclk);
    {psel, penable, pwrite, paddr, pwdata} <= {1'b1, 1'b0, w, a, d};
    @(posedge pclk);
    penable <= 1'b1;
    k = 0;
    do
    begin
      @(posedge pclk);
      k++;
    end while (pready !== 1'b1 && k < 50);
    if (pready !== 1'b1) tmo();
    rd = prdata;
    er = pslverr;
    {psel, penable} <= 2'b00;
  endtask
  // one-cycle key pulse
  task automatic kp(input logic r);
    {run_key, off_key} <= {r, !r};
    @(posedge pclk);
    {run_key, off_key} <= 2'b00;
  endtask
  // main sequence
  initial
  begin
    {pclk, presetn, psel, penable, pwrite, run_key, off_key} = '0;
    {ext_enable, pon_on, gp_sync_pulse_output_req, men, paddr, pwdata, mper} = {44'h0, 16'd20};
    {err_total, checked} = '0;
    rows = '{'{8'h00, 32'h0, 1'b0}, '{8'h04, 32'h1e, 1'b0}, '{8'h08, 32'h1e, 1'b0},
      '{8'h0c, 32'h7d0, 1'b0}, '{8'h10, 32'h1388, 1'b0}, '{8'h14, 32'h0, 1'b0},
      '{8'h18, 32'h1, 1'b0}, '{8'h1c, 32'h0, 1'b0}, '{8'h20, 32'h0, 1'b1}};
    cyc(5);
    chk(32'(magnet_on), 32'h0);
    chk(32'(bus_node_address), 32'h1);
    cyc(5);
    presetn <= 1'b1;
    cyc(20);
    chk(32'(magnet_on), 32'h0);
    foreach (rows[i])
    begin
      apb(1'b0, rows[i].a, 32'h0);
      chk(rd, rows[i].d);
      chk(32'(er), 32'(rows[i].e));
    end
    $display("test regs done");
    kp(1'b1);
    wt(1'b0, 1'b1, 10);
    kp(1'b0);
    wt(1'b0, 1'b0, 10);
    apb(1'b1, 8'h00, 32'h4);
    kp(1'b1);
    cyc(20);
    chk(32'(magnet_on), 32'h0);
    ext_enable <= 1'b1;
    wt(1'b0, 1'b1, 10);
    ext_enable <= 1'b0;
    wt(1'b0, 1'b0, 10);
    $display("test keys done");
    apb(1'b1, 8'h00, 32'h0);
    {gp_sync_pulse_output_req, ext_enable} <= 2'b11;
    wt(1'b0, 1'b1, 10);
    cyc(40);
    chk(32'(air_out), 32'h0);
    chk(32'({sync_pulse_output, pin3_reserved}), 32'h2);
    {gp_sync_pulse_output_req, ext_enable} <= 2'b00;
    wt(1'b0, 1'b0, 10);
    $display("test no air done");
    apb(1'b1, 8'h04, 32'h3);
    apb(1'b1, 8'h08, 32'h5);
    apb(1'b1, 8'h00, 32'h8);
    ext_enable <= 1'b1;
    wt(1'b1, 1'b0, 10);
    wt(1'b1, 1'b1, 100);
    rng(20, 45);
    ext_enable <= 1'b0;
    wt(1'b1, 1'b0, 5);
    wt(1'b0, 1'b0, 100);
    rng(40, 62);
    ext_enable <= 1'b1;
    wt(1'b1, 1'b1, 100);
    ext_enable <= 1'b0;
    cyc(15);
    chk(32'(air_out), 32'h1);
    ext_enable <= 1'b1;
    wt(1'b1, 1'b1, 5);
    rng(0, 3);
    ext_enable <= 1'b0;
    wt(1'b0, 1'b0, 100);
    $display("test air done");
    apb(1'b1, 8'h10, 32'd40);
    apb(1'b1, 8'h14, 32'd5);
    apb(1'b1, 8'h00, 32'h11);
    ext_enable <= 1'b1;
    cyc(30);
    chk(32'({magnet_on, pin3_reserved}), 32'h1);
    men <= 1'b1;
    wt(1'b0, 1'b1, 100);
    chk(32'({freq_ctrl_en, amp_ctrl_en, gp_in3}), 32'h2);
    wh(0);
    wh(1);
    rng(7, 10);
    wh(0);
    men <= 1'b0;
    wt(1'b0, 1'b0, 100);
    rng(36, 48);
    ext_enable <= 1'b0;
    $display("test slave done");
    apb(1'b1, 8'h0c, 32'd9);
    apb(1'b1, 8'h00, 32'h12);
    ext_enable <= 1'b1;
    wt(1'b0, 1'b1, 20);
    chk(32'({freq_ctrl_en, pin3_reserved}), 32'h3);
    wh(2);
    cyc(1);
    wh(2);
    chk(32'(n), 32'd9);
    ext_enable <= 1'b0;
    wt(1'b0, 1'b0, 10);
    apb(1'b1, 8'h18, 32'h5a);
    cyc(1);
    chk(32'(bus_node_address), 32'h5a);
    apb(1'b0, 8'h18, 32'h0);
    chk(rd, 32'h5a);
    $display("test master done");
    {pon_on, presetn} <= 2'b10;
    cyc(2);
    presetn <= 1'b1;
    wt(1'b0, 1'b1, 5);
    apb(1'b1, 8'h00, 32'h4);
    apb(1'b0, 8'h1c, 32'h0);
    chk(32'(rd[6]), 32'h0);
    kp(1'b0);
    wt(1'b0, 1'b0, 10);
    $display("test power-up done");
    conclude();
  end
endmodule
